// file: rtl/wfs_pkg.sv
// wavelet field stream framer: shared constants, state codes, delimiter codes
// assumes one 200 MHz clock and a 32-bit host fifo path into the codec
// Operation
// - fields go out as field one then field two, repeating; a sequence always ends on field two, so its field count is even.
// - the stream is closed by the sequence end marker when decoding.
// - field = start marker, timecode words, first block, remaining blocks, in order.
// - field one opens with its own marker, field two with its own.
// - first block has no delimiter: type tag, quantizer step, payload.
// - the first block of every field carries sub-band block 6.
// - exactly 41 further block records follow the first block.
// - each further record: delimiter variant, quantizer step, payload.
// - block 9 type 4, then 20,22,19,23,17,25,16,26,14,28,13,29 type 3.
// - then 11 type 1, 31 type 1, 10 type 3, 32 type 1, 8 type 3.
// - every delimiter code starts on a 32-bit word boundary.
// - any block delimiter may become type 5 for a zero-data block.
package wfs_pkg;
    // ==========================================================
    // stream codes
    localparam logic [63:0] FIELD_ONE_START_MARKER = 64'hFFFFFFFF40000000;
    localparam logic [63:0] FIELD_TWO_START_MARKER = 64'hFFFFFFFF41000000;
    localparam logic [63:0] SEQUENCE_END_MARKER = 64'hFFFFFFFF4F000000;
    localparam logic [63:0] BLOCK_DELIM_TYPE1 = 64'hFFFFFFFF42000001;
    localparam logic [63:0] BLOCK_DELIM_TYPE2 = 64'hFFFFFFFF42000002;
    localparam logic [63:0] BLOCK_DELIM_FIRST_BLOCK_TYPE_TAG = 64'hFFFFFFFF42000003;
    localparam logic [63:0] BLOCK_DELIM_TYPE4 = 64'hFFFFFFFF42000004;
    localparam logic [63:0] BLOCK_DELIM_TYPE5 = 64'hFFFFFFFF42000005;
    localparam logic [31:0] FIRST_BLOCK_TYPE_TAG = 32'h00000003;
    // ==========================================================
    // delimiter variant codes as stored in the order table
    localparam logic [2:0] DELIM_NONE = 3'h0;
    localparam logic [2:0] DELIM_T1 = 3'h1;
    localparam logic [2:0] DELIM_T2 = 3'h2;
    localparam logic [2:0] DELIM_T3 = 3'h3;
    localparam logic [2:0] DELIM_T4 = 3'h4;
    localparam logic [2:0] DELIM_T5 = 3'h5;
    // ==========================================================
    // counts and reset values
    localparam logic [1:0] TC_LAST = 2'h1;       // two timecode words
    localparam logic [5:0] LAST_IDX = 6'h29;     // record index 41
    localparam logic [5:0] FIRST_BLOCK = 6'h06;
    localparam logic [5:0] IDX_RESET = 6'h00;
    localparam logic [15:0] STEP_PAD = 16'h0000;
    // ==========================================================
    // framer states, one-hot
    typedef enum logic [10:0] {
        S_IDLE = 11'h001,
        S_SOF_HI = 11'h002,
        S_SOF_LO = 11'h004,
        S_TC = 11'h008,
        S_TAG = 11'h010,
        S_DLM_HI = 11'h020,
        S_DLM_LO = 11'h040,
        S_STEP = 11'h080,
        S_PAY = 11'h100,
        S_EOS_HI = 11'h200,
        S_EOS_LO = 11'h400
    } wfs_state_t;
endpackage

// file: rtl/wfs_order_rom.sv
// wavelet field stream framer: fixed block order table, registered read
// assumes the address is presented one cycle before the data is needed
`timescale 1ns/1ps
`default_nettype none
module wfs_order_rom (
    input wire logic i_clock,
    input wire logic [5:0] i_addr,
    output logic [5:0] o_block,
    output logic [2:0] o_dtype
);
    logic [8:0] next_word;
    logic [8:0] word;

    // ==========================================================
    // order table: record index to block number and delimiter variant
    always_comb begin
        unique case (i_addr)
            6'h00: next_word = {6'h06, wfs_pkg::DELIM_NONE};
            6'h01: next_word = {6'h09, wfs_pkg::DELIM_T4};
            6'h02: next_word = {6'h14, wfs_pkg::DELIM_T3};
            6'h03: next_word = {6'h16, wfs_pkg::DELIM_T3};
            6'h04: next_word = {6'h13, wfs_pkg::DELIM_T3};
            6'h05: next_word = {6'h17, wfs_pkg::DELIM_T3};
            6'h06: next_word = {6'h11, wfs_pkg::DELIM_T3};
            6'h07: next_word = {6'h19, wfs_pkg::DELIM_T3};
            6'h08: next_word = {6'h10, wfs_pkg::DELIM_T3};
            6'h09: next_word = {6'h1A, wfs_pkg::DELIM_T3};
            6'h0A: next_word = {6'h0E, wfs_pkg::DELIM_T3};
            6'h0B: next_word = {6'h1C, wfs_pkg::DELIM_T3};
            6'h0C: next_word = {6'h0D, wfs_pkg::DELIM_T3};
            6'h0D: next_word = {6'h1D, wfs_pkg::DELIM_T3};
            6'h0E: next_word = {6'h0B, wfs_pkg::DELIM_T1};
            6'h0F: next_word = {6'h1F, wfs_pkg::DELIM_T1};
            6'h10: next_word = {6'h0A, wfs_pkg::DELIM_T3};
            6'h11: next_word = {6'h20, wfs_pkg::DELIM_T1};
            6'h12: next_word = {6'h08, wfs_pkg::DELIM_T3};
            6'h13: next_word = {6'h22, wfs_pkg::DELIM_T1};
            6'h14: next_word = {6'h07, wfs_pkg::DELIM_T3};
            6'h15: next_word = {6'h23, wfs_pkg::DELIM_T1};
            6'h16: next_word = {6'h05, wfs_pkg::DELIM_T3};
            6'h17: next_word = {6'h25, wfs_pkg::DELIM_T1};
            6'h18: next_word = {6'h04, wfs_pkg::DELIM_T3};
            6'h19: next_word = {6'h26, wfs_pkg::DELIM_T1};
            6'h1A: next_word = {6'h02, wfs_pkg::DELIM_T3};
            6'h1B: next_word = {6'h28, wfs_pkg::DELIM_T1};
            6'h1C: next_word = {6'h01, wfs_pkg::DELIM_T3};
            6'h1D: next_word = {6'h29, wfs_pkg::DELIM_T1};
            6'h1E: next_word = {6'h00, wfs_pkg::DELIM_T4};
            6'h1F: next_word = {6'h27, wfs_pkg::DELIM_T2};
            6'h20: next_word = {6'h0C, wfs_pkg::DELIM_T4};
            6'h21: next_word = {6'h24, wfs_pkg::DELIM_T2};
            6'h22: next_word = {6'h0F, wfs_pkg::DELIM_T4};
            6'h23: next_word = {6'h21, wfs_pkg::DELIM_T2};
            6'h24: next_word = {6'h12, wfs_pkg::DELIM_T4};
            6'h25: next_word = {6'h1E, wfs_pkg::DELIM_T2};
            6'h26: next_word = {6'h15, wfs_pkg::DELIM_T4};
            6'h27: next_word = {6'h1B, wfs_pkg::DELIM_T2};
            6'h28: next_word = {6'h18, wfs_pkg::DELIM_T4};
            6'h29: next_word = {6'h03, wfs_pkg::DELIM_T2};
            default: next_word = {wfs_pkg::FIRST_BLOCK, wfs_pkg::DELIM_NONE};
        endcase
    end

    // registered read port
    always_ff @(posedge i_clock) begin
        word <= next_word;
    end

    assign o_block = word[8:3];
    assign o_dtype = word[2:0];
endmodule
`default_nettype wire

// file: rtl/wfs_framer.sv
// wavelet field stream framer: host-side writer of the compressed field stream
// assumes the codec host fifo takes one 32-bit word per write strobe and
// raises a full pin asynchronously; it must leave a few words of slack
`timescale 1ns/1ps
`default_nettype none
module wfs_framer (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [63:0] i_timecode,
    input wire logic [15:0] i_step,
    input wire logic i_zero_block,
    input wire logic i_pay_valid,
    input wire logic [31:0] i_pay_data,
    input wire logic i_pay_last,
    input wire logic i_hd_full,
    output logic o_pay_ready,
    output logic [5:0] o_cur_block,
    output logic o_field_two,
    output logic o_busy,
    output logic o_seq_done,
    output logic [31:0] o_hd_data,
    output logic o_hd_write,
    output logic o_hd_oe_b
);
    wfs_pkg::wfs_state_t state, next_state;
    logic [5:0] idx, next_idx;
    logic [1:0] tc_cnt, next_tc_cnt;
    logic field_two, next_field_two;
    logic stop_pend, next_stop_pend;
    logic zero, next_zero;
    logic [63:0] tc, next_tc;
    logic [31:0] next_hd_data;
    logic next_hd_write, next_pay_ready, next_busy, next_seq_done;
    logic full_m, full_s;
    logic go, accept, block_end;
    logic [2:0] rom_dtype;
    logic [2:0] dtype_now;

    // delimiter variant to its 64-bit code
    function automatic logic [63:0] delim_code(input logic [2:0] t);
        unique case (t)
            wfs_pkg::DELIM_T1: delim_code = wfs_pkg::BLOCK_DELIM_TYPE1;
            wfs_pkg::DELIM_T2: delim_code = wfs_pkg::BLOCK_DELIM_TYPE2;
            wfs_pkg::DELIM_T3: delim_code = wfs_pkg::BLOCK_DELIM_FIRST_BLOCK_TYPE_TAG;
            wfs_pkg::DELIM_T4: delim_code = wfs_pkg::BLOCK_DELIM_TYPE4;
            default: delim_code = wfs_pkg::BLOCK_DELIM_TYPE5;
        endcase
    endfunction

    // field flag to its start marker
    function automatic logic [63:0] field_code(input logic two);
        field_code = two ? wfs_pkg::FIELD_TWO_START_MARKER : wfs_pkg::FIELD_ONE_START_MARKER;
    endfunction

    // ==========================================================
    // block order table
    wfs_order_rom u_order (
        .i_clock(i_clock),
        .i_addr(next_idx),
        .o_block(o_cur_block),
        .o_dtype(rom_dtype)
    );

    // ==========================================================
    // full pin synchroniser
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            full_m <= 1'b1;
            full_s <= 1'b1;
        end else begin
            full_m <= i_hd_full;
            full_s <= full_m;
        end
    end

    assign go = !full_s;
    assign accept = i_pay_valid && o_pay_ready;
    assign dtype_now = i_zero_block ? wfs_pkg::DELIM_T5 : rom_dtype;
    // full 64-bit codes of the marker and delimiter pairs, split into halves below
    wire logic [63:0] sof_code = field_code(field_two);
    wire logic [63:0] dlm_hi_code = delim_code(dtype_now);
    wire logic [63:0] dlm_lo_code = delim_code(zero ? wfs_pkg::DELIM_T5 : rom_dtype);

    // ==========================================================
    // framer next state and word emission
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_tc_cnt = tc_cnt;
        next_field_two = field_two;
        next_stop_pend = stop_pend | i_stop;
        next_zero = zero;
        next_tc = tc;
        next_hd_data = o_hd_data;
        next_hd_write = 1'b0;
        next_seq_done = 1'b0;
        block_end = 1'b0;
        unique case (state)
            wfs_pkg::S_IDLE: begin
                if (i_start) begin
                    next_stop_pend = i_stop;
                    next_field_two = 1'b0;
                    next_state = wfs_pkg::S_SOF_HI;
                end
            end
            wfs_pkg::S_SOF_HI: begin
                if (go) begin
                    next_hd_data = sof_code[63:32];
                    next_hd_write = 1'b1;
                    next_tc = i_timecode;
                    next_state = wfs_pkg::S_SOF_LO;
                end
            end
            wfs_pkg::S_SOF_LO: begin
                if (go) begin
                    next_hd_data = sof_code[31:0];
                    next_hd_write = 1'b1;
                    next_tc_cnt = 2'h0;
                    next_state = wfs_pkg::S_TC;
                end
            end
            wfs_pkg::S_TC: begin
                if (go) begin
                    next_hd_data = (tc_cnt == 2'h0) ? tc[63:32] : tc[31:0];
                    next_hd_write = 1'b1;
                    next_tc_cnt = tc_cnt + 2'h1;
                    if (tc_cnt == wfs_pkg::TC_LAST) begin
                        next_idx = wfs_pkg::IDX_RESET;
                        next_zero = 1'b0;
                        next_state = wfs_pkg::S_TAG;
                    end
                end
            end
            wfs_pkg::S_TAG: begin
                if (go) begin
                    next_hd_data = wfs_pkg::FIRST_BLOCK_TYPE_TAG;
                    next_hd_write = 1'b1;
                    next_state = wfs_pkg::S_STEP;
                end
            end
            wfs_pkg::S_DLM_HI: begin
                if (go) begin
                    next_zero = i_zero_block;
                    next_hd_data = dlm_hi_code[63:32];
                    next_hd_write = 1'b1;
                    next_state = wfs_pkg::S_DLM_LO;
                end
            end
            wfs_pkg::S_DLM_LO: begin
                if (go) begin
                    next_hd_data = dlm_lo_code[31:0];
                    next_hd_write = 1'b1;
                    next_state = wfs_pkg::S_STEP;
                end
            end
            wfs_pkg::S_STEP: begin
                if (go) begin
                    next_hd_data = {wfs_pkg::STEP_PAD, i_step};
                    next_hd_write = 1'b1;
                    if (zero) begin
                        block_end = 1'b1;
                    end else begin
                        next_state = wfs_pkg::S_PAY;
                    end
                end
            end
            wfs_pkg::S_PAY: begin
                if (accept) begin
                    next_hd_data = i_pay_data;
                    next_hd_write = 1'b1;
                    block_end = i_pay_last;
                end
            end
            wfs_pkg::S_EOS_HI: begin
                if (go) begin
                    next_hd_data = wfs_pkg::SEQUENCE_END_MARKER[63:32];
                    next_hd_write = 1'b1;
                    next_state = wfs_pkg::S_EOS_LO;
                end
            end
            wfs_pkg::S_EOS_LO: begin
                if (go) begin
                    next_hd_data = wfs_pkg::SEQUENCE_END_MARKER[31:0];
                    next_hd_write = 1'b1;
                    next_seq_done = 1'b1;
                    next_state = wfs_pkg::S_IDLE;
                end
            end
        endcase
        // closing a block: next record, next field, or end of sequence
        if (block_end) begin
            next_zero = 1'b0;
            if (idx == wfs_pkg::LAST_IDX) begin
                if (field_two && stop_pend) begin
                    next_state = wfs_pkg::S_EOS_HI;
                end else begin
                    next_field_two = !field_two;
                    next_state = wfs_pkg::S_SOF_HI;
                end
            end else begin
                next_idx = idx + 6'h01;
                next_state = wfs_pkg::S_DLM_HI;
            end
        end
        next_pay_ready = (next_state == wfs_pkg::S_PAY) && go;
        next_busy = (next_state != wfs_pkg::S_IDLE);
    end

    // framer registers
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state <= wfs_pkg::S_IDLE;
            idx <= wfs_pkg::IDX_RESET;
            tc_cnt <= 2'h0;
            field_two <= 1'b0;
            stop_pend <= 1'b0;
            zero <= 1'b0;
            tc <= 64'h0000000000000000;
            o_hd_data <= 32'h00000000;
            o_hd_write <= 1'b0;
            o_hd_oe_b <= 1'b1;
            o_pay_ready <= 1'b0;
            o_busy <= 1'b0;
            o_seq_done <= 1'b0;
            o_field_two <= 1'b0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            tc_cnt <= next_tc_cnt;
            field_two <= next_field_two;
            stop_pend <= next_stop_pend;
            zero <= next_zero;
            tc <= next_tc;
            o_hd_data <= next_hd_data;
            o_hd_write <= next_hd_write;
            o_hd_oe_b <= !next_hd_write;
            o_pay_ready <= next_pay_ready;
            o_busy <= next_busy;
            o_seq_done <= next_seq_done;
            o_field_two <= next_field_two;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    sequence sof_hi_s;
        state == wfs_pkg::S_SOF_HI && go;
    endsequence
    sequence field_close_s;
        block_end && idx == wfs_pkg::LAST_IDX && !(field_two && stop_pend);
    endsequence

    field_alt_a: assert property (field_close_s |=> field_two != $past(field_two))
        else $error("field did not alternate");
    seq_end_a: assert property (state == wfs_pkg::S_EOS_LO && go |=> o_hd_write
        && o_hd_data == wfs_pkg::SEQUENCE_END_MARKER[31:0] ##1 state == wfs_pkg::S_IDLE)
        else $error("sequence end not closed");
    rec_order_a: assert property (state == wfs_pkg::S_SOF_LO && go
        |=> state == wfs_pkg::S_TC ##[1:300] state == wfs_pkg::S_TAG)
        else $error("timecode not after start marker");
    start_code_a: assert property (sof_hi_s |=> o_hd_write
        && o_hd_data == $past(sof_code[63:32]))
        else $error("wrong field start marker");
    first_tag_a: assert property (state == wfs_pkg::S_TAG && go |=> o_hd_write
        && o_hd_data == wfs_pkg::FIRST_BLOCK_TYPE_TAG && state == wfs_pkg::S_STEP)
        else $error("first block tag wrong");
    first_six_a: assert property (state == wfs_pkg::S_TAG
        |-> o_cur_block == wfs_pkg::FIRST_BLOCK && rom_dtype == wfs_pkg::DELIM_NONE)
        else $error("first block is not block 6");
    count_end_a: assert property (block_end && idx != wfs_pkg::LAST_IDX
        |=> state == wfs_pkg::S_DLM_HI && idx == $past(idx) + 6'h01)
        else $error("block count off");
    delim_step_a: assert property (state == wfs_pkg::S_DLM_LO && go
        |=> state == wfs_pkg::S_STEP ##[1:300] o_hd_write && $past(state) == wfs_pkg::S_STEP)
        else $error("step not after delimiter");
    order_head_a: assert property (state == wfs_pkg::S_DLM_HI && idx == 6'h01
        |-> o_cur_block == 6'h09 && rom_dtype == wfs_pkg::DELIM_T4)
        else $error("block 9 not first delimited");
    order_tail_a: assert property (state == wfs_pkg::S_DLM_HI && idx == 6'h0E
        |-> o_cur_block == 6'h0B && rom_dtype == wfs_pkg::DELIM_T1)
        else $error("block 11 out of place");
    code_pair_a: assert property (state == wfs_pkg::S_DLM_HI && go |=> (o_hd_write
        && state == wfs_pkg::S_DLM_LO) ##[1:1000] (o_hd_write && $past(state) == wfs_pkg::S_DLM_LO))
        else $error("delimiter halves split");
    zero_code_a: assert property (state == wfs_pkg::S_DLM_HI && go && i_zero_block
        |=> o_hd_data == wfs_pkg::BLOCK_DELIM_TYPE5[63:32] && zero)
        else $error("zero block delimiter wrong");
    step_word_a: assert property (state == wfs_pkg::S_STEP && go && !zero
        |=> o_hd_write && o_hd_data[31:16] == wfs_pkg::STEP_PAD && state == wfs_pkg::S_PAY)
        else $error("step word malformed");
endmodule
`default_nettype wire

// file: tb/wfs_codec_model.sv
// wavelet field stream framer bench: behavioural codec host fifo on the write path
// assumes one 32-bit word per write strobe, enable low while the word is driven
`timescale 1ns/1ps
`default_nettype none
module wfs_codec_model (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [31:0] i_data,
    input wire logic i_write,
    input wire logic i_oe_b,
    input wire logic i_slow,
    output logic o_full,
    output logic o_err
);
    logic [2:0] phase;
    logic hi_seen;
    logic [6:0] count;
    logic in_field;
    // ==========================================================
    // full pin and stream parser
    // count block delimiters between field starts, flag a wrong count
    always @(posedge i_clock) begin
        if (!i_rst_b) begin
            phase <= 3'h0;
            o_full <= 1'b0;
            hi_seen <= 1'b0;
            count <= 7'h00;
            in_field <= 1'b0;
            o_err <= 1'b0;
        end else begin
            phase <= phase + 3'h1;
            o_full <= i_slow && (phase > 3'h4); // full 3 of 8 cycles, slack takes the lag
            if (i_write && !i_oe_b) begin
                hi_seen <= (i_data == 32'hFFFFFFFF);
                if (hi_seen && (i_data == wfs_pkg::FIELD_ONE_START_MARKER[31:0] ||
                        i_data == wfs_pkg::FIELD_TWO_START_MARKER[31:0])) begin
                    if (in_field && count != 7'h29) begin
                        o_err <= 1'b1;
                    end
                    count <= 7'h00;
                    in_field <= 1'b1;
                end else if (hi_seen && i_data[31:8] == wfs_pkg::BLOCK_DELIM_TYPE1[31:8]) begin
                    count <= count + 7'h01;
                end else if (hi_seen && i_data == wfs_pkg::SEQUENCE_END_MARKER[31:0]) begin
                    if (count != 7'h29) begin
                        o_err <= 1'b1;
                    end
                    in_field <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/test_wfs_framer.sv
// wavelet field stream framer bench: drives payload, predicts the whole word stream
// assumes the framer and the codec model files are compiled before this one
`timescale 1ns/1ps
`default_nettype none
module test_wfs_framer;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_start = 1'b0;
    logic i_stop = 1'b0;
    logic [63:0] i_timecode = 64'h0;
    logic [15:0] i_step = 16'h0;
    logic i_zero_block = 1'b0;
    logic i_pay_valid = 1'b0;
    logic [31:0] i_pay_data = 32'h0;
    logic i_pay_last = 1'b0;
    logic i_hd_full;
    logic o_pay_ready, o_field_two, o_busy, o_seq_done, o_hd_write, o_hd_oe_b, slow, err;
    logic [5:0] o_cur_block;
    logic [31:0] o_hd_data, mask;
    logic [32:0] exp_q[$];
    logic [1:0] plen [0:4][0:41];
    logic [15:0] seed = 16'h0050;
    logic go = 1'b0;
    logic running = 1'b0;
    logic zero_mode = 1'b0;
    logic pulse;
    logic [5:0] blk [0:40] = '{6'h09, 6'h14, 6'h16, 6'h13, 6'h17, 6'h11, 6'h19, 6'h10, 6'h1A,
        6'h0E, 6'h1C, 6'h0D, 6'h1D, 6'h0B, 6'h1F, 6'h0A, 6'h20, 6'h08, 6'h22, 6'h07, 6'h23,
        6'h05, 6'h25, 6'h04, 6'h26, 6'h02, 6'h28, 6'h01, 6'h29, 6'h00, 6'h27, 6'h0C, 6'h24,
        6'h0F, 6'h21, 6'h12, 6'h1E, 6'h15, 6'h1B, 6'h18, 6'h03};
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int nfield, stop_field, pf, pr, pk;
    // ==========================================================
    // clock, design and codec model
    always #2.5 i_clock = ~i_clock;
    wfs_framer u_wfs_framer (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_start(i_start),
        .i_stop(i_stop), .i_timecode(i_timecode), .i_step(i_step), .i_zero_block(i_zero_block),
        .i_pay_valid(i_pay_valid), .i_pay_data(i_pay_data), .i_pay_last(i_pay_last),
        .i_hd_full(i_hd_full), .o_pay_ready(o_pay_ready), .o_cur_block(o_cur_block),
        .o_field_two(o_field_two), .o_busy(o_busy), .o_seq_done(o_seq_done),
        .o_hd_data(o_hd_data), .o_hd_write(o_hd_write), .o_hd_oe_b(o_hd_oe_b));
    wfs_codec_model u_wfs_codec_model (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_data(o_hd_data),
        .i_write(o_hd_write), .i_oe_b(o_hd_oe_b), .i_slow(slow), .o_full(i_hd_full), .o_err(err));
    // ==========================================================
    // helpers
    function automatic logic [15:0] next_lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // delimiter variant of remaining record r (0..40)
    function automatic logic [63:0] delim(input int r);
        if (r == 0 || (r > 28 && r[0])) return wfs_pkg::BLOCK_DELIM_TYPE4;
        if (r < 13 || r == 15 || r == 17 || (r > 17 && r < 29 && r[0]))
            return wfs_pkg::BLOCK_DELIM_FIRST_BLOCK_TYPE_TAG;
        if (r < 29) return wfs_pkg::BLOCK_DELIM_TYPE1;
        return wfs_pkg::BLOCK_DELIM_TYPE2;
    endfunction
    function automatic logic [31:0] pdata(input int f, input int r, input int k);
        return mask ^ {8'(f), 8'(r), 16'(k)};
    endfunction
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic put(input logic [31:0] w);
        exp_q.push_back({1'b0, w});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one sequence of n fields, stop given after the first block of field sf
    task automatic run_seq(input int n, input int sf, input logic z, input logic s);
        logic [63:0] code;
        nfield = n;
        stop_field = sf;
        zero_mode = z;
        slow = s;
        i_zero_block = z;
        seed = next_lfsr(seed);
        i_step = seed;
        i_timecode = {seed, ~seed, 16'h5AC3 ^ seed, 16'h0F1E};
        mask = {~seed, 16'hC3A5};
        for (int f = 0; f < n; f++) begin
            code = f[0] ? wfs_pkg::FIELD_TWO_START_MARKER : wfs_pkg::FIELD_ONE_START_MARKER;
            put(code[63:32]);
            put(code[31:0]);
            put(i_timecode[63:32]);
            put(i_timecode[31:0]);
            put(wfs_pkg::FIRST_BLOCK_TYPE_TAG);
            put({16'h0000, i_step});
            for (int r = 0; r < 42; r++) begin
                seed = next_lfsr(seed);
                plen[f][r] = seed[1:0];
                if (r > 0) begin
                    code = z ? wfs_pkg::BLOCK_DELIM_TYPE5 : delim(r - 1);
                    put(code[63:32]);
                    put(code[31:0]);
                    put({16'h0000, i_step});
                end
                for (int k = 0; k <= int'(plen[f][r]) && (r == 0 || !z); k++) put(pdata(f, r, k));
            end
        end
        put(wfs_pkg::SEQUENCE_END_MARKER[63:32]);
        exp_q.push_back({1'b1, wfs_pkg::SEQUENCE_END_MARKER[31:0]});
        pf = 0;
        pr = 0;
        pk = 0;
        running = 1'b1;
        @(posedge i_clock);
        go = 1'b1;
        @(posedge i_clock);
        go = 1'b0;
        while (exp_q.size() != 0) @(posedge i_clock);
        repeat (4) @(posedge i_clock);
        #1;
        check("busy_err", 64'h0, {o_busy, err});
        running = 1'b0;
    endtask
    // ==========================================================
    // payload driver: checks record position at each accepted word
    always @(posedge i_clock) begin
        pulse = 1'b0;
        if (running && i_pay_valid && o_pay_ready) begin
            check("field_block", 64'({pf[0], (pr == 0) ? 6'h06 : blk[pr - 1]}),
                64'({o_field_two, o_cur_block}));
            if (i_pay_last) begin
                pulse = (pr == 0) && (pf == stop_field);
                pk = 0;
                pr = (zero_mode || pr == 41) ? 0 : pr + 1;
                pf = pf + ((pr == 0) ? 1 : 0);
            end else begin
                pk = pk + 1;
            end
        end
        #1;
        i_start = go || pulse; // pulse also tries a start while busy
        i_stop = pulse;
        if (running) seed = next_lfsr(seed);
        i_pay_valid = running && (pf < nfield) && (seed[1:0] != 2'h0);
        i_pay_data = pdata(pf, pr, pk);
        i_pay_last = (pk == int'(plen[pf][pr]));
    end
    // ==========================================================
    // stream monitor: each written word takes the oldest note
    always @(posedge i_clock) begin
        #1;
        if (i_rst_b) begin
            check("hd_oe_b", 64'(!o_hd_write), 64'(o_hd_oe_b));
            if (o_hd_write === 1'b1 && exp_q.size() == 0) begin
                check("hd_extra", 64'h0, 64'({o_seq_done, o_hd_data}));
            end else if (o_hd_write === 1'b1) begin
                check("hd_word", 64'(exp_q.pop_front()), 64'({o_seq_done, o_hd_data}));
                check("busy", 64'(!o_seq_done), 64'(o_busy));
            end else begin
                check("seq_done", 64'h0, 64'(o_seq_done));
            end
        end
    end
    // ==========================================================
    // hang guard and main sequence
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        slow = 1'b0;
        repeat (12) @(posedge i_clock);
        #1;
        i_rst_b = 1'b1;
        repeat (3) @(posedge i_clock);
        #1;
        run_seq(2, 0, 1'b0, 1'b0);
        run_seq(4, 3, 1'b0, 1'b1);
        run_seq(2, 1, 1'b1, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
